// ==== inc/sial_defines.vh ====
// register map, reset values and function codes of the servo io allocation block
`ifndef SIAL_DEFINES_VH
`define SIAL_DEFINES_VH

// ****************************************
// register byte offsets
// ****************************************
`define SIAL_OFF_IN_MAP_A   8'h00
`define SIAL_OFF_IN_MAP_B   8'h04
`define SIAL_OFF_OUT_MAP    8'h08
`define SIAL_OFF_POLARITY   8'h0C
`define SIAL_OFF_FWD_INT    8'h10
`define SIAL_OFF_REV_INT    8'h14
`define SIAL_OFF_FWD_EXT    8'h18
`define SIAL_OFF_REV_EXT    8'h1C
`define SIAL_OFF_POS_CAP    8'h20
`define SIAL_OFF_NEG_CAP    8'h24
`define SIAL_OFF_MOT_MAX    8'h28
`define SIAL_OFF_CTRL       8'h2C
`define SIAL_OFF_STATUS     8'h30

// ****************************************
// reset values
// ****************************************
`define SIAL_RST_IN_MAP_A   12'h210
`define SIAL_RST_IN_MAP_B   8'h43
`define SIAL_RST_OUT_MAP    24'hF2F1F0
`define SIAL_RST_IN_POL     5'h00
`define SIAL_RST_OUT_POL    3'h0
`define SIAL_RST_INT_PCT    9'h12C
`define SIAL_RST_EXT_PCT    9'h064
`define SIAL_RST_CAP_PCT    9'h15E
`define SIAL_RST_MOT_MAX    9'h15E
`define SIAL_PCT_MAX        9'h15E

// ****************************************
// field positions
// ****************************************
`define SIAL_POL_OUT_LSB    8
`define SIAL_ST_FUNC_LSB    16
`define SIAL_ST_OUT_LSB     27
`define SIAL_ST_TLIM_BIT    30

// ****************************************
// input function codes
// ****************************************
`define SIAL_IN_SERVO_ON    4'h0
`define SIAL_IN_FWD_INH     4'h1
`define SIAL_IN_REV_INH     4'h2
`define SIAL_IN_FWD_CL      4'h3
`define SIAL_IN_REV_CL      4'h4
`define SIAL_IN_GAIN_SW     4'h5
`define SIAL_IN_HOME_REF    4'h6
`define SIAL_IN_REMOTE      4'h7
`define SIAL_IN_PROBE1      4'h8
`define SIAL_IN_PROBE2      4'h9
`define SIAL_IN_FSTOP       4'hA
`define SIAL_IN_FUNCS       11

// ****************************************
// output function codes
// ****************************************
`define SIAL_OUT_TLIM       4'h3
`define SIAL_OUT_RSVD       4'hC

// ****************************************
// bus answers
// ****************************************
`define SIAL_RESP_OKAY      2'h0
`define SIAL_RESP_SLVERR    2'h2
`define SIAL_SEL_NONE       4'hF

`endif

// ==== logic/sial_pin_sync.v ====
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module sial_pin_sync #(
  parameter W = 5
) (
  input  wire         aclk,     // control clock
  input  wire         aresetn,  // sync reset, active low
  input  wire [W-1:0] pin_in,   // raw connector levels
  output wire [W-1:0] pin_lvl   // accepted levels
);
  reg  [W-1:0] s1_r;
  reg  [W-1:0] s2_r;
  reg  [W-1:0] s3_r;
  reg  [W-1:0] lvl_r;
  wire [W-1:0] lvl_nxt;
  genvar i;

  always @(posedge aclk) begin
    if (!aresetn) begin
      s1_r <= {W{1'b0}};
      s2_r <= {W{1'b0}};
      s3_r <= {W{1'b0}};
      lvl_r <= {W{1'b0}};
    end else begin
      s1_r <= pin_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      lvl_r <= lvl_nxt;
    end
  end

  // stage one feeds only stage two; a change counts once two and three agree
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      assign lvl_nxt[i] = (s2_r[i] == s3_r[i]) ? s3_r[i] : lvl_r[i];
    end
  endgenerate

  assign pin_lvl = lvl_r;
endmodule

// ==== logic/sial_top.v ====
// servo io allocation and torque limit block with axi4-lite registers
`timescale 1ns/1ps
`include "sial_defines.vh"
module sial_top #(
  parameter TQ_W = 16
) (
  input  wire                   aclk,          // control clock, 100 MHz
  input  wire                   aresetn,       // sync reset, active low
  input  wire [7:0]             s_axi_awaddr,  // write address
  input  wire                   s_axi_awvalid, // write address valid
  output reg                    s_axi_awready, // write address ready
  input  wire [31:0]            s_axi_wdata,   // write data
  input  wire [3:0]             s_axi_wstrb,   // write byte strobes
  input  wire                   s_axi_wvalid,  // write data valid
  output reg                    s_axi_wready,  // write data ready
  output reg  [1:0]             s_axi_bresp,   // write response
  output reg                    s_axi_bvalid,  // write response valid
  input  wire                   s_axi_bready,  // write response ready
  input  wire [7:0]             s_axi_araddr,  // read address
  input  wire                   s_axi_arvalid, // read address valid
  output reg                    s_axi_arready, // read address ready
  output reg  [31:0]            s_axi_rdata,   // read data
  output reg  [1:0]             s_axi_rresp,   // read response
  output reg                    s_axi_rvalid,  // read data valid
  input  wire                   s_axi_rready,  // read data ready
  input  wire [4:0]             io_in_pin,     // connector input positions 1..5
  output reg  [2:0]             io_out_pin,    // connector output groups 1..3
  output reg  [10:0]            in_func,       // decoded input functions by code
  input  wire [13:0]            drv_stat,      // drive status by output code
  input  wire signed [TQ_W-1:0] torque_cmd,    // torque request, percent
  output reg  signed [TQ_W-1:0] torque_out,    // clamped torque, percent
  output reg                    torque_limited // clamp active
);

  // ****************************************
  // helpers
  // ****************************************
  function [3:0] reg_sel;
    input [7:0] a;
    begin
      case (a)
        `SIAL_OFF_IN_MAP_A: reg_sel = 4'h0;
        `SIAL_OFF_IN_MAP_B: reg_sel = 4'h1;
        `SIAL_OFF_OUT_MAP:  reg_sel = 4'h2;
        `SIAL_OFF_POLARITY: reg_sel = 4'h3;
        `SIAL_OFF_FWD_INT:  reg_sel = 4'h4;
        `SIAL_OFF_REV_INT:  reg_sel = 4'h5;
        `SIAL_OFF_FWD_EXT:  reg_sel = 4'h6;
        `SIAL_OFF_REV_EXT:  reg_sel = 4'h7;
        `SIAL_OFF_POS_CAP:  reg_sel = 4'h8;
        `SIAL_OFF_NEG_CAP:  reg_sel = 4'h9;
        `SIAL_OFF_MOT_MAX:  reg_sel = 4'hA;
        `SIAL_OFF_CTRL:     reg_sel = 4'hB;
        `SIAL_OFF_STATUS:   reg_sel = 4'hC;
        default:            reg_sel = `SIAL_SEL_NONE;
      endcase
    end
  endfunction

  function [31:0] wmerge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0]  strb;
    integer k;
    begin
      wmerge = old;
      for (k = 0; k < 4; k = k + 1) begin
        if (strb[k])
          wmerge[k*8 +: 8] = nw[k*8 +: 8];
      end
    end
  endfunction

  // settings above the top of the range are held at the top
  function [8:0] pct_clip;
    input [31:0] v;
    begin
      if (v > {23'h000000, `SIAL_PCT_MAX})
        pct_clip = `SIAL_PCT_MAX;
      else
        pct_clip = v[8:0];
    end
  endfunction

  function [8:0] min9;
    input [8:0] a;
    input [8:0] b;
    begin
      min9 = (a < b) ? a : b;
    end
  endfunction

  // last matching position wins, so position 5 has top priority
  function pick_in;
    input [19:0] codes;
    input [4:0]  act;
    input integer code;
    integer p;
    begin
      pick_in = 1'b0;
      for (p = 0; p < 5; p = p + 1) begin
        if (codes[p*4 +: 4] == code)
          pick_in = act[p];
      end
    end
  endfunction

  // ****************************************
  // configuration registers
  // ****************************************
  reg  [11:0] map_a_r;
  reg  [7:0]  map_b_r;
  reg  [23:0] omap_r;
  reg  [4:0]  in_pol_r;
  reg  [2:0]  out_pol_r;
  reg  [8:0]  fint_r;
  reg  [8:0]  rint_r;
  reg  [8:0]  fext_r;
  reg  [8:0]  rext_r;
  reg  [8:0]  pcap_r;
  reg  [8:0]  ncap_r;
  reg  [8:0]  mmax_r;
  reg         ext_en_r;

  reg  [7:0]  awaddr_r;
  reg  [31:0] wdata_r;
  reg  [3:0]  wstrb_r;
  reg  [31:0] old_w;
  reg  [31:0] rd_w;
  wire [3:0]  wsel;
  wire [3:0]  rsel;
  wire [31:0] new_w;
  wire        wr_go;
  wire        wr_ok;

  wire [4:0]  pin_lvl;
  wire [4:0]  pin_act;
  wire [10:0] func_nxt;
  wire [15:0] ostat;
  wire [2:0]  out_nxt;
  reg  [8:0]  fwd_sel;
  reg  [8:0]  rev_sel;
  wire [8:0]  fwd_lim;
  wire [8:0]  rev_lim;
  wire signed [TQ_W-1:0] f_bound;
  wire signed [TQ_W-1:0] r_bound;
  reg  signed [TQ_W-1:0] tq_nxt;
  reg         tlim_nxt;

  assign wsel  = reg_sel(awaddr_r);
  assign rsel  = reg_sel(s_axi_araddr);
  assign wr_go = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  assign wr_ok = wr_go && (wsel != `SIAL_SEL_NONE) && (wsel != 4'hC);
  assign new_w = wmerge(old_w, wdata_r, wstrb_r);

  always @* begin
    case (wsel)
      4'h0:    old_w = {20'h00000, map_a_r};
      4'h1:    old_w = {24'h000000, map_b_r};
      4'h2:    old_w = {8'h00, omap_r};
      4'h3:    old_w = {21'h000000, out_pol_r, 3'h0, in_pol_r};
      4'h4:    old_w = {23'h000000, fint_r};
      4'h5:    old_w = {23'h000000, rint_r};
      4'h6:    old_w = {23'h000000, fext_r};
      4'h7:    old_w = {23'h000000, rext_r};
      4'h8:    old_w = {23'h000000, pcap_r};
      4'h9:    old_w = {23'h000000, ncap_r};
      4'hA:    old_w = {23'h000000, mmax_r};
      4'hB:    old_w = {31'h00000000, ext_en_r};
      default: old_w = 32'h00000000;
    endcase
  end

  // settings take effect on the edge after the write is accepted
  always @(posedge aclk) begin
    if (!aresetn) begin
      map_a_r   <= `SIAL_RST_IN_MAP_A;
      map_b_r   <= `SIAL_RST_IN_MAP_B;
      omap_r    <= `SIAL_RST_OUT_MAP;
      in_pol_r  <= `SIAL_RST_IN_POL;
      out_pol_r <= `SIAL_RST_OUT_POL;
      fint_r    <= `SIAL_RST_INT_PCT;
      rint_r    <= `SIAL_RST_INT_PCT;
      fext_r    <= `SIAL_RST_EXT_PCT;
      rext_r    <= `SIAL_RST_EXT_PCT;
      pcap_r    <= `SIAL_RST_CAP_PCT;
      ncap_r    <= `SIAL_RST_CAP_PCT;
      mmax_r    <= `SIAL_RST_MOT_MAX;
      ext_en_r  <= 1'b0;
    end else if (wr_ok) begin
      case (wsel)
        4'h0: map_a_r <= new_w[11:0];
        4'h1: map_b_r <= new_w[7:0];
        4'h2: omap_r  <= new_w[23:0];
        4'h3: begin
          in_pol_r  <= new_w[4:0];
          out_pol_r <= new_w[`SIAL_POL_OUT_LSB +: 3];
        end
        4'h4: fint_r  <= pct_clip(new_w);
        4'h5: rint_r  <= pct_clip(new_w);
        4'h6: fext_r  <= pct_clip(new_w);
        4'h7: rext_r  <= pct_clip(new_w);
        4'h8: pcap_r  <= pct_clip(new_w);
        4'h9: ncap_r  <= pct_clip(new_w);
        4'hA: mmax_r  <= pct_clip(new_w);
        4'hB: ext_en_r <= new_w[0];
        default: ext_en_r <= ext_en_r;
      endcase
    end
  end

  // ****************************************
  // axi4-lite write channel
  // ****************************************
  // address and data are taken in either order; one write in flight
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `SIAL_RESP_OKAY;
      awaddr_r      <= 8'h00;
      wdata_r       <= 32'h00000000;
      wstrb_r       <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awaddr_r      <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wdata_r      <= s_axi_wdata;
        wstrb_r      <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? `SIAL_RESP_OKAY : `SIAL_RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // ****************************************
  // axi4-lite read channel
  // ****************************************
  always @* begin
    case (rsel)
      4'hC: begin
        rd_w = 32'h00000000;
        rd_w[4:0] = pin_lvl;
        rd_w[`SIAL_ST_FUNC_LSB +: 11] = in_func;
        rd_w[`SIAL_ST_OUT_LSB +: 3] = io_out_pin;
        rd_w[`SIAL_ST_TLIM_BIT] = torque_limited;
      end
      4'h0:    rd_w = {20'h00000, map_a_r};
      4'h1:    rd_w = {24'h000000, map_b_r};
      4'h2:    rd_w = {8'h00, omap_r};
      4'h3:    rd_w = {21'h000000, out_pol_r, 3'h0, in_pol_r};
      4'h4:    rd_w = {23'h000000, fint_r};
      4'h5:    rd_w = {23'h000000, rint_r};
      4'h6:    rd_w = {23'h000000, fext_r};
      4'h7:    rd_w = {23'h000000, rext_r};
      4'h8:    rd_w = {23'h000000, pcap_r};
      4'h9:    rd_w = {23'h000000, ncap_r};
      4'hA:    rd_w = {23'h000000, mmax_r};
      4'hB:    rd_w = {31'h00000000, ext_en_r};
      default: rd_w = 32'h00000000;
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `SIAL_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_w;
      s_axi_rresp   <= (rsel == `SIAL_SEL_NONE) ? `SIAL_RESP_SLVERR : `SIAL_RESP_OKAY;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
    end
  end

  // ****************************************
  // input allocation
  // ****************************************
  sial_pin_sync #(
    .W (5)
  ) u_pin_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .pin_in  (io_in_pin),
    .pin_lvl (pin_lvl)
  );

  // polarity is applied per pin before any sharing or priority
  assign pin_act = pin_lvl ^ in_pol_r;

  // every function scans all positions on its own, so one function may sit on many pins
  genvar f;
  generate
    for (f = 0; f < `SIAL_IN_FUNCS; f = f + 1) begin : g_in
      assign func_nxt[f] = pick_in({map_b_r, map_a_r}, pin_act, f);
    end
  endgenerate

  always @(posedge aclk) begin
    if (!aresetn)
      in_func <= 11'h000;
    else
      in_func <= func_nxt;
  end

  // ****************************************
  // output allocation
  // ****************************************
  // reserved and undefined codes index a constant zero
  assign ostat = {2'b00, drv_stat[13], 1'b0, drv_stat[11:10], 1'b0,
                  drv_stat[8:4], torque_limited, drv_stat[2:0]};

  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_out
      assign out_nxt[g] = (ostat[omap_r[g*8 +: 4]] | ostat[omap_r[g*8+4 +: 4]])
                          ^ out_pol_r[g];
    end
  endgenerate

  always @(posedge aclk) begin
    if (!aresetn)
      io_out_pin <= 3'h0;
    else
      io_out_pin <= out_nxt;
  end

  // ****************************************
  // torque limiting
  // ****************************************
  // host keeps external inputs low unless the machine needs them
  always @* begin
    if (ext_en_r) begin
      fwd_sel = in_func[`SIAL_IN_FWD_CL] ? min9(fint_r, fext_r) : fext_r;
      rev_sel = in_func[`SIAL_IN_REV_CL] ? min9(rint_r, rext_r) : rext_r;
    end else begin
      fwd_sel = fint_r;
      rev_sel = rint_r;
    end
  end

  assign fwd_lim = min9(min9(fwd_sel, pcap_r), mmax_r);
  assign rev_lim = min9(min9(rev_sel, ncap_r), mmax_r);
  assign f_bound = $signed({{(TQ_W-9){1'b0}}, fwd_lim});
  assign r_bound = -$signed({{(TQ_W-9){1'b0}}, rev_lim});

  always @* begin
    tq_nxt   = torque_cmd;
    tlim_nxt = 1'b0;
    if (torque_cmd > f_bound) begin
      tq_nxt   = f_bound;
      tlim_nxt = 1'b1;
    end else if (torque_cmd < r_bound) begin
      tq_nxt   = r_bound;
      tlim_nxt = 1'b1;
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      torque_out     <= {TQ_W{1'b0}};
      torque_limited <= 1'b0;
    end else begin
      torque_out     <= tq_nxt;
      torque_limited <= tlim_nxt;
    end
  end

endmodule

// ==== tb/sial_monitor.sv ====
// assertion checker bound to the servo io allocation top
`timescale 1ns/1ps
module sial_monitor #(
  parameter TQ_W = 16
) (
  input wire                   aclk,           // control clock
  input wire                   aresetn,        // sync reset, active low
  input wire                   s_axi_awvalid,  // write address valid
  input wire                   s_axi_awready,  // write address ready
  input wire                   s_axi_wvalid,   // write data valid
  input wire                   s_axi_wready,   // write data ready
  input wire [1:0]             s_axi_bresp,    // write response
  input wire                   s_axi_bvalid,   // write response valid
  input wire                   s_axi_bready,   // write response ready
  input wire                   s_axi_arvalid,  // read address valid
  input wire                   s_axi_arready,  // read address ready
  input wire [31:0]            s_axi_rdata,    // read data
  input wire                   s_axi_rvalid,   // read data valid
  input wire                   s_axi_rready,   // read data ready
  input wire signed [TQ_W-1:0] torque_cmd,     // torque request
  input wire signed [TQ_W-1:0] torque_out,     // clamped torque
  input wire                   torque_limited  // clamp active
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // ****************************************
  // register bus
  // ****************************************
  AST_AR_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer missing");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  AST_R_BUSY: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken during answer");
  AST_B_ANSWER: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid)
    else $error("write answer missing");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  AST_B_BUSY: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken during answer");

  // ****************************************
  // torque clamp
  // ****************************************
  AST_TQ_MAX: assert property (torque_out <= 350 && torque_out >= -350)
    else $error("torque beyond ceiling");
  AST_TQ_FWD: assert property ($past(aresetn) && $past(torque_cmd) >= 0
    |-> torque_out >= 0 && torque_out <= $past(torque_cmd))
    else $error("forward clamp wrong");
  AST_TQ_REV: assert property ($past(aresetn) && $past(torque_cmd) < 0
    |-> torque_out <= 0 && torque_out >= $past(torque_cmd))
    else $error("reverse clamp wrong");
  AST_TQ_FLAG: assert property ($past(aresetn)
    |-> torque_limited == (torque_out != $past(torque_cmd)))
    else $error("clamp flag wrong");
endmodule

bind sial_top sial_monitor #(.TQ_W(TQ_W)) u_mon (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .torque_cmd(torque_cmd),
  .torque_out(torque_out), .torque_limited(torque_limited));

// ==== tb/sial_field_model.sv ====
// host and field wiring model driving connector levels, status and torque
`timescale 1ns/1ps
module sial_field_model (
  input  wire                aclk,       // control clock
  input  wire         [4:0]  pin_set,    // wanted connector levels
  input  wire         [13:0] stat_set,   // wanted drive status
  input  wire  signed [15:0] cmd_set,    // wanted torque request
  output logic        [4:0]  io_in_pin,  // connector inputs
  output logic        [13:0] drv_stat,   // drive status
  output logic signed [15:0] torque_cmd  // torque request
);
  initial begin
    io_in_pin = 5'h00;
    drv_stat = 14'h0000;
    torque_cmd = 16'sh0000;
  end
  // external limit pins only change on request from the bench
  always @(posedge aclk) begin
    io_in_pin  <= pin_set;
    drv_stat   <= stat_set;
    torque_cmd <= cmd_set;
  end
endmodule

// ==== tb/servo_io_alloc_torque_limit_tb_top.sv ====
// self-checking bench for the servo io allocation block
`timescale 1ns/1ps
module servo_io_alloc_torque_limit_tb_top;
  logic               aclk = 1'b0;
  logic               aresetn = 1'b0;
  logic [7:0]         awaddr = 8'h00;
  logic [7:0]         araddr = 8'h00;
  logic [31:0]        wdata = 32'h0;
  logic               awvalid = 1'b0;
  logic               wvalid = 1'b0;
  logic               arvalid = 1'b0;
  wire                awready, wready, bvalid, arready, rvalid, tlim;
  wire  [1:0]         bresp, rresp;
  wire  [31:0]        rdata;
  wire  [4:0]         pin;
  wire  [2:0]         opin;
  wire  [10:0]        func;
  wire  [13:0]        stat;
  wire  signed [15:0] cmd, tq;
  logic [4:0]         pin_s = 5'h00;
  logic [13:0]        stat_s = 14'h0000;
  logic signed [15:0] cmd_s = 16'sh0000;
  integer             fails = 0;
  integer             num_checks = 0;
  integer             i;
  localparam [13:0]   OMASK = 14'h2DF7;
  logic [31:0]        rst_v [0:11] = '{32'h210, 32'h43, 32'hF2F1F0, 32'h0, 32'h12C, 32'h12C,
                                       32'h64, 32'h64, 32'h15E, 32'h15E, 32'h15E, 32'h0};

  sial_top #(.TQ_W(16)) uut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1),
    .io_in_pin(pin), .io_out_pin(opin), .in_func(func), .drv_stat(stat),
    .torque_cmd(cmd), .torque_out(tq), .torque_limited(tlim));

  sial_field_model u_fm (.aclk(aclk), .pin_set(pin_s), .stat_set(stat_s), .cmd_set(cmd_s),
    .io_in_pin(pin), .drv_stat(stat), .torque_cmd(cmd));

  always #5 aclk = ~aclk;

  // ****************************************
  // tasks
  // ****************************************
  task chk(input string nm, input [31:0] got, input [31:0] exp);
    begin
      num_checks = num_checks + 1;
      if (got !== exp) begin
        fails = fails + 1;
        $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      end
    end
  endtask

  // ready lines are held high, so the answer is taken at the edge it is seen
  task wr(input [7:0] a, input [31:0] d, input [1:0] er);
    integer n;
    begin
      n = 0;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      do begin
        @(posedge aclk);
        if (awready) awvalid <= 1'b0;
        if (wready) wvalid <= 1'b0;
        n = n + 1;
      end while (bvalid !== 1'b1 && n < 50);
      // a wait that runs out counts as a mismatch
      if (bvalid !== 1'b1) fails = fails + 1;
      chk("bresp", bresp, er);
    end
  endtask

  task rd(input [7:0] a, input [31:0] ed, input [1:0] er);
    integer n;
    begin
      n = 0;
      araddr <= a;
      arvalid <= 1'b1;
      do begin
        @(posedge aclk);
        if (arready) arvalid <= 1'b0;
        n = n + 1;
      end while (rvalid !== 1'b1 && n < 50);
      if (rvalid !== 1'b1) fails = fails + 1;
      chk("rdata", rdata, ed);
      chk("rresp", rresp, er);
    end
  endtask

  // covers the pin synchroniser plus decode latency
  task st;
    repeat (10) @(posedge aclk);
  endtask

  task tq_chk(input signed [15:0] c, input [4:0] p, input [31:0] e, input l);
    begin
      cmd_s <= c;
      pin_s <= p;
      st;
      chk("torque", tq, e);
      chk("tlim", tlim, l);
    end
  endtask

  task end_sim;
    begin
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) begin
        $display("Test passed");
      end else begin
        $display("Test failed");
      end
      $finish;
    end
  endtask

  // ****************************************
  // tests
  // ****************************************
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (i = 0; i < 12; i = i + 1) rd(8'(i * 4), rst_v[i], 2'h0);
    rd(8'h40, 32'h0, 2'h2);
    wr(8'h30, 32'hFFFF, 2'h2);
    wr(8'h10, 32'h190, 2'h0);
    rd(8'h10, 32'h15E, 2'h0);
    wr(8'h10, 32'h12C, 2'h0);
    $display("test registers done");
    tq_chk(16'sh140, 5'h00, 32'sh12C, 1'b1);
    tq_chk(-16'sh190, 5'h00, -32'sh12C, 1'b1);
    tq_chk(16'sh64, 5'h00, 32'sh64, 1'b0);
    wr(8'h10, 32'hC8, 2'h0);
    tq_chk(16'shFA, 5'h00, 32'shC8, 1'b1);
    wr(8'h28, 32'h64, 2'h0);
    tq_chk(16'shFA, 5'h00, 32'sh64, 1'b1);
    wr(8'h28, 32'h15E, 2'h0);
    $display("test internal limits done");
    wr(8'h2C, 32'h1, 2'h0);
    wr(8'h18, 32'hFA, 2'h0);
    tq_chk(16'sh12C, 5'h00, 32'shFA, 1'b1);
    tq_chk(16'sh12C, 5'h08, 32'shC8, 1'b1);
    wr(8'h14, 32'h96, 2'h0);
    wr(8'h1C, 32'hFA, 2'h0);
    tq_chk(-16'sh12C, 5'h00, -32'shFA, 1'b1);
    tq_chk(-16'sh12C, 5'h10, -32'sh96, 1'b1);
    wr(8'h20, 32'h50, 2'h0);
    tq_chk(16'sh12C, 5'h00, 32'sh50, 1'b1);
    wr(8'h24, 32'h50, 2'h0);
    tq_chk(-16'sh12C, 5'h00, -32'sh50, 1'b1);
    wr(8'h20, 32'h15E, 2'h0);
    wr(8'h24, 32'h15E, 2'h0);
    wr(8'h2C, 32'h0, 2'h0);
    $display("test external limits done");
    wr(8'h04, 32'hFF, 2'h0);
    for (i = 0; i < 11; i = i + 1) begin
      wr(8'h00, 32'hFF0 | i, 2'h0);
      pin_s <= 5'h01;
      st;
      chk("in_func", func, 32'h1 << i);
    end
    wr(8'h0C, 32'h1, 2'h0);
    pin_s <= 5'h00;
    st;
    chk("in_pol", func, 32'h400);
    wr(8'h0C, 32'h0, 2'h0);
    wr(8'h00, 32'hFF5, 2'h0);
    wr(8'h04, 32'h5F, 2'h0);
    pin_s <= 5'h01;
    st;
    chk("in_prio_lo", func, 32'h0);
    pin_s <= 5'h10;
    st;
    chk("in_prio_hi", func, 32'h20);
    $display("test inputs done");
    pin_s <= 5'h00;
    cmd_s <= 16'sh0000;
    for (i = 0; i < 14; i = i + 1) begin
      wr(8'h08, 32'hFFFFF0 | i, 2'h0);
      stat_s <= 14'h1 << i;
      st;
      chk("out_code", opin, {31'h0, OMASK[i]});
    end
    wr(8'h08, 32'hFFFF21, 2'h0);
    stat_s <= 14'h0004;
    st;
    chk("out_or", opin, 32'h1);
    wr(8'h0C, 32'h100, 2'h0);
    stat_s <= 14'h0000;
    st;
    chk("out_pol", opin, 32'h1);
    wr(8'h0C, 32'h0, 2'h0);
    wr(8'h08, 32'hFFFFF3, 2'h0);
    cmd_s <= 16'sh190;
    st;
    chk("out_clamp", opin, 32'h1);
    $display("test outputs done");
    end_sim;
  end

  initial begin
    #400000;
    fails = fails + 1;
    end_sim;
  end
endmodule
